// ---- design/sleep_idle_mode_control.sv ----
// sleep and idle power-managed mode controller
//
// Behaviour
// - sleep with idle select clear stops primary and fast oscillators, clears status flags
// - rc source runs with watchdog; secondary oscillator runs when enabled
// - sleep wake waits for selected source, or skips the wait when two-speed/fail-safe, without forcing the fast osc on
// - primary ready flag set whenever primary clocks the device after sleep wake
// - wake never changes idle select or clock source select
// - idle stops cpu clock, peripherals keep selected source, flags unchanged on primary idle entry
// - idle exits only on interrupt, watchdog time-out or reset
// - idle wake holds cpu for start delay, then runs from same source
// - watchdog time-out in sleep or idle wakes, never resets
// - primary idle keeps primary clock running, no warm-up needed
// - primary idle entered with idle select set and select field zero
// - primary ready flag stays set in and after primary idle
// - secondary idle stops primary, clears primary ready, sets secondary active
// - sleep ignored for secondary idle when secondary oscillator disabled
// - peripheral clocks withheld until enabled secondary oscillator runs
// - secondary idle wake keeps secondary oscillator for peripherals and cpu
// - upper select bit set enters internal idle, stops primary, clears ready
// - nonzero freq or source select enables fast osc; stable after settle time
// - already stable fast osc keeps stable flag set through idle entry
// - all-zero freq and source select leave fast osc off, stable flag clear
// - internal idle wake keeps internal multiplexer for peripherals and cpu
// - internal idle keeps rc source with watchdog or fail-safe monitor
// - idle select sampled when the sleep instruction executes
// - secondary active only while secondary drives; stable flag while fast osc stable
`timescale 1ns/10ps
module sleep_idle_mode_control #(
    parameter int CPU_START_LEN = pm_mode_pkg::CPU_START_CYCLES,
    parameter int SETTLE_LEN    = pm_mode_pkg::SETTLE_CYCLES
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       sleep_exec,
    input  wire logic                       idle_on_sleep_select,
    input  wire logic [1:0]                 clock_source_select,
    input  wire logic                       secondary_osc_enable,
    input  wire logic                       secondary_osc_running,
    input  wire logic                       primary_osc_ready,
    input  wire logic [2:0]                 internal_freq_select,
    input  wire logic                       low_freq_source_select,
    input  wire logic                       watchdog_enable,
    input  wire logic                       fail_safe_enable,
    input  wire logic                       two_speed_enable,
    input  wire logic                       wake_interrupt,
    input  wire logic                       watchdog_timeout,
    output pm_mode_pkg::status_type         status,
    output pm_mode_pkg::clock_ctrl_type     clock_ctrl,
    output pm_mode_pkg::pm_state_type       mode,
    output logic                            watchdog_reset_req
);
    import pm_mode_pkg::*;

    logic [1:0]   osc_sync;
    logic [1:0]   prim_sync;
    logic [1:0]   wake_sync;
    logic [1:0]   wdt_sync;
    logic         sec_running;
    logic         prim_ready;
    logic         wake_irq;
    logic         wdt_to;
    pm_state_type state;
    pm_state_type next_state;
    logic         idle_sel;
    logic         next_idle_sel;
    logic [1:0]   src_sel;
    logic [1:0]   next_src_sel;
    logic [CNT_W-1:0] delay_cnt;
    logic [CNT_W-1:0] next_delay_cnt;
    logic [CNT_W-1:0] settle_cnt;
    logic [CNT_W-1:0] next_settle_cnt;
    status_type     next_status;
    clock_ctrl_type next_clock_ctrl;
    logic           next_watchdog_reset_req;
    logic           wake_event;
    logic           fast_req;
    logic           fast_stable;

    function automatic logic is_internal(input logic [1:0] sel);
        is_internal = sel[SEL_UPPER_BIT];
    endfunction

    // pin-side inputs pass two flip-flops; the first stage feeds only the second
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            osc_sync  <= 2'h0;
            prim_sync <= 2'h0;
            wake_sync <= 2'h0;
            wdt_sync  <= 2'h0;
        end else begin
            osc_sync  <= {osc_sync[0], secondary_osc_running};
            prim_sync <= {prim_sync[0], primary_osc_ready};
            wake_sync <= {wake_sync[0], wake_interrupt};
            wdt_sync  <= {wdt_sync[0], watchdog_timeout};
        end
    end
    assign sec_running = osc_sync[1];
    assign prim_ready  = prim_sync[1];
    assign wake_irq    = wake_sync[1];
    assign wdt_to      = wdt_sync[1];

    assign wake_event  = wake_irq | wdt_to;
    assign fast_req    = (internal_freq_select != 3'h0) | low_freq_source_select;
    assign fast_stable = fast_req && (settle_cnt == CNT_W'(SETTLE_LEN));

    always_comb begin
        next_state              = state;
        next_idle_sel           = idle_sel;
        next_src_sel            = src_sel;
        next_delay_cnt          = delay_cnt;
        next_settle_cnt         = settle_cnt;
        next_status             = status;
        next_watchdog_reset_req = 1'b0;
        // settle counter runs while the fast internal output is requested
        if (!fast_req) begin
            next_settle_cnt = '0;
        end else if (settle_cnt != CNT_W'(SETTLE_LEN)) begin
            next_settle_cnt = settle_cnt + CNT_W'(1);
        end
        case (state)
            RUN_MODE: begin
                next_src_sel = clock_source_select;
                next_idle_sel = idle_on_sleep_select;
                if (wdt_to) begin
                    next_watchdog_reset_req = 1'b1;
                end
                if (sleep_exec) begin
                    next_idle_sel = idle_on_sleep_select;
                    if (!idle_on_sleep_select) begin
                        next_state  = SLEEP_MODE;
                        next_status = '0;
                    end else if (clock_source_select == SEL_SECONDARY &&
                                 !secondary_osc_enable) begin
                        next_state = RUN_MODE;
                    end else begin
                        next_state = IDLE_MODE;
                        // the source switch happens on entry, so the flags follow at once
                        if (clock_source_select == SEL_SECONDARY) begin
                            next_status.primary_clock_ready_flag    = 1'b0;
                            next_status.secondary_clock_active_flag = sec_running;
                        end else if (is_internal(clock_source_select)) begin
                            next_status.primary_clock_ready_flag    = 1'b0;
                            next_status.secondary_clock_active_flag = 1'b0;
                            next_status.internal_osc_stable_flag    = fast_stable;
                        end
                    end
                end else begin
                    next_status.primary_clock_ready_flag =
                        (clock_source_select == SEL_PRIMARY) & prim_ready;
                    next_status.secondary_clock_active_flag =
                        (clock_source_select == SEL_SECONDARY) & sec_running;
                    next_status.internal_osc_stable_flag = fast_stable;
                end
            end
            SLEEP_MODE: begin
                if (wake_event) begin
                    next_delay_cnt = '0;
                    next_state = (two_speed_enable | fail_safe_enable) ?
                                 START_MODE : WAKE_WAIT_MODE;
                end
            end
            WAKE_WAIT_MODE: begin
                if ((src_sel == SEL_PRIMARY && prim_ready) ||
                    (src_sel == SEL_SECONDARY && sec_running) ||
                    is_internal(src_sel)) begin
                    next_state = START_MODE;
                end
            end
            IDLE_MODE: begin
                if (src_sel == SEL_PRIMARY) begin
                    next_status.primary_clock_ready_flag = 1'b1;
                end else if (src_sel == SEL_SECONDARY) begin
                    next_status.primary_clock_ready_flag    = 1'b0;
                    next_status.secondary_clock_active_flag = sec_running;
                end else begin
                    next_status.primary_clock_ready_flag = 1'b0;
                    next_status.secondary_clock_active_flag = 1'b0;
                    next_status.internal_osc_stable_flag = fast_stable;
                end
                if (wake_event) begin
                    next_delay_cnt = '0;
                    next_state = START_MODE;
                end
            end
            START_MODE: begin
                next_delay_cnt = delay_cnt + CNT_W'(1);
                if (delay_cnt >= CNT_W'(CPU_START_LEN - 1)) begin
                    next_state = RUN_MODE;
                end
                if (src_sel == SEL_PRIMARY) begin
                    next_status.primary_clock_ready_flag = prim_ready;
                end
            end
            default: begin
                next_state = RUN_MODE;
            end
        endcase
    end

    always_comb begin
        next_clock_ctrl = '0;
        // oscillator enables follow the selection that the next state will use,
        // so a source switch on idle entry shows in the first idle cycle
        next_clock_ctrl.low_power_rc_en = watchdog_enable |
            (is_internal(next_src_sel) & fail_safe_enable);
        next_clock_ctrl.secondary_osc_run = secondary_osc_enable;
        next_clock_ctrl.fast_internal_osc_en = fast_req & is_internal(next_src_sel);
        next_clock_ctrl.primary_osc_en = (next_src_sel == SEL_PRIMARY);
        case (next_state)
            RUN_MODE: begin
                next_clock_ctrl.cpu_clock_en    = 1'b1;
                next_clock_ctrl.periph_clock_en = 1'b1;
            end
            IDLE_MODE: begin
                next_clock_ctrl.periph_clock_en = (next_src_sel != SEL_SECONDARY) |
                                                  sec_running;
            end
            START_MODE: begin
                next_clock_ctrl.periph_clock_en = 1'b1;
            end
            SLEEP_MODE: begin
                next_clock_ctrl.primary_osc_en = 1'b0;
                next_clock_ctrl.fast_internal_osc_en =
                    two_speed_enable | fail_safe_enable;
            end
            WAKE_WAIT_MODE: begin
                // the selected source is restarted here, else the wait never ends
                next_clock_ctrl.fast_internal_osc_en =
                    two_speed_enable | fail_safe_enable;
            end
            default: begin
                next_clock_ctrl.cpu_clock_en = 1'b0;
            end
        endcase
        if (next_state == SLEEP_MODE) begin
            next_clock_ctrl.fast_internal_osc_en = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state              <= RUN_MODE;
            idle_sel           <= 1'b0;
            src_sel            <= SEL_PRIMARY;
            delay_cnt          <= '0;
            settle_cnt         <= '0;
            status             <= '0;
            clock_ctrl         <= '0;
            watchdog_reset_req <= 1'b0;
        end else begin
            state              <= next_state;
            idle_sel           <= next_idle_sel;
            src_sel            <= next_src_sel;
            delay_cnt          <= next_delay_cnt;
            settle_cnt         <= next_settle_cnt;
            status             <= next_status;
            clock_ctrl         <= next_clock_ctrl;
            watchdog_reset_req <= next_watchdog_reset_req;
        end
    end

    assign mode = state;
endmodule

// ---- shared/pm_mode_pkg.sv ----
// package for the sleep and idle mode controller
package pm_mode_pkg;
    localparam logic [1:0] SEL_PRIMARY   = 2'h0;
    localparam logic [1:0] SEL_SECONDARY = 2'h1;
    localparam int         SEL_UPPER_BIT = 1;
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         CPU_START_DELAY_NS = 2000;
    localparam int         SETTLE_TIME_NS     = 1000;
    localparam int         CPU_START_CYCLES =
        (CPU_START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         SETTLE_CYCLES =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         CNT_W = 16;

    typedef enum logic [5:0] {
        RUN_MODE       = 6'h01,
        SLEEP_MODE     = 6'h02,
        IDLE_MODE      = 6'h04,
        WAKE_WAIT_MODE = 6'h08,
        START_MODE     = 6'h10,
        SRC_WAIT_MODE  = 6'h20
    } pm_state_type;

    typedef struct packed {
        logic primary_clock_ready_flag;
        logic internal_osc_stable_flag;
        logic secondary_clock_active_flag;
    } status_type;

    typedef struct packed {
        logic cpu_clock_en;
        logic periph_clock_en;
        logic primary_osc_en;
        logic secondary_osc_run;
        logic fast_internal_osc_en;
        logic low_power_rc_en;
    } clock_ctrl_type;
endpackage

// ---- bench/sleep_idle_mode_control_chk.sv ----
// assertion checker for the sleep and idle mode controller
`timescale 1ns/10ps
module sleep_idle_mode_control_chk
    import pm_mode_pkg::*;
#(parameter int CPU_START_LEN = 3) (
    input logic                       clk_sys,
    input logic                       rst_n,
    input logic                       sleep_exec,
    input logic                       idle_on_sleep_select,
    input logic [1:0]                 clock_source_select,
    input logic                       secondary_osc_enable,
    input logic                       secondary_osc_running,
    input logic [2:0]                 internal_freq_select,
    input logic                       low_freq_source_select,
    input logic                       watchdog_enable,
    input logic                       fail_safe_enable,
    input logic                       two_speed_enable,
    input logic                       wake_interrupt,
    input logic                       watchdog_timeout,
    input pm_mode_pkg::status_type    status,
    input pm_mode_pkg::clock_ctrl_type clock_ctrl,
    input pm_mode_pkg::pm_state_type  mode,
    input logic                       watchdog_reset_req
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [15:0] start_cnt;
    logic [15:0] next_start_cnt;
    wire run_sleep = sleep_exec && mode == RUN_MODE;
    wire sec_off = clock_source_select == SEL_SECONDARY && !secondary_osc_enable;
    wire low_power = mode == SLEEP_MODE || mode == IDLE_MODE;
    wire in_idle = mode == IDLE_MODE;
    always_comb next_start_cnt = (mode == START_MODE) ? start_cnt + 16'h1 : 16'h0;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) start_cnt <= 16'h0;
        else start_cnt <= next_start_cnt;
    end
    a_sleep_entry: assert property (run_sleep && !idle_on_sleep_select |=>
        mode == SLEEP_MODE && status == 3'h0 && !clock_ctrl.cpu_clock_en) else $error("bad sleep");
    a_idle_entry: assert property (run_sleep && idle_on_sleep_select && !sec_off |=>
        in_idle && !clock_ctrl.cpu_clock_en) else $error("bad idle entry");
    a_sec_refused: assert property (run_sleep && idle_on_sleep_select && sec_off |=>
        mode == RUN_MODE) else $error("sleep not ignored");
    a_start_length: assert property ($fell(mode == START_MODE) |->
        start_cnt == CPU_START_LEN && mode == RUN_MODE) else $error("bad start delay");
    a_cpu_held: assert property (mode == START_MODE || mode == WAKE_WAIT_MODE |->
        !clock_ctrl.cpu_clock_en) else $error("cpu clocked early");
    a_idle_exit: assert property (in_idle ##1 !in_idle |->
        $past(wake_interrupt, 3) || $past(watchdog_timeout, 3)) else $error("idle left unasked");
    a_no_wdt_reset: assert property (low_power |-> !watchdog_reset_req)
        else $error("watchdog reset while asleep");
    a_primary_idle_mode: assert property (in_idle && clock_source_select == SEL_PRIMARY |->
        clock_ctrl.primary_osc_en && status.primary_clock_ready_flag) else $error("bad primary_idle_mode");
    a_secondary_idle_mode: assert property (in_idle && clock_source_select == SEL_SECONDARY |->
        !clock_ctrl.primary_osc_en && !status.primary_clock_ready_flag
        && (secondary_osc_running || !clock_ctrl.periph_clock_en)) else $error("bad secondary_idle_mode");
    a_int_idle: assert property (in_idle && clock_source_select[SEL_UPPER_BIT] |->
        !clock_ctrl.primary_osc_en && (internal_freq_select != 3'h0 || low_freq_source_select
        || !status.internal_osc_stable_flag && !clock_ctrl.fast_internal_osc_en))
        else $error("bad int idle");
    a_keep_sources: assert property (low_power |->
        (!(watchdog_enable || in_idle && fail_safe_enable) || clock_ctrl.low_power_rc_en)
        && (!secondary_osc_enable || clock_ctrl.secondary_osc_run)) else $error("source stopped");
    a_wait_gate: assert property (mode == WAKE_WAIT_MODE |->
        !two_speed_enable && !fail_safe_enable) else $error("waited needlessly");
    c_sleep: cover property (mode == SLEEP_MODE);
    c_idle: cover property (in_idle);
    c_wait: cover property (mode == WAKE_WAIT_MODE);
endmodule
bind sleep_idle_mode_control sleep_idle_mode_control_chk #(.CPU_START_LEN(CPU_START_LEN)) chk_u (.*);

// ---- bench/osc_cpu_model.sv ----
// oscillator sources that need a warm-up before they report ready
`timescale 1ns/10ps
module osc_cpu_model
    import pm_mode_pkg::*;
#(parameter int WARM = 5) (
    input  logic                         clk_sys,
    input  logic                         rst_n,
    input  pm_mode_pkg::clock_ctrl_type  clock_ctrl,
    input  logic                         secondary_osc_enable,
    output logic                         primary_osc_ready,
    output logic                         secondary_osc_running
);
    logic [3:0] pri_cnt;
    logic [3:0] sec_cnt;
    assign primary_osc_ready = pri_cnt == 4'(WARM);
    assign secondary_osc_running = sec_cnt == 4'(WARM);
    // a disabled source drops its ready level on the next clock edge
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pri_cnt <= 4'h0;
            sec_cnt <= 4'h0;
        end else begin
            pri_cnt <= !clock_ctrl.primary_osc_en ? 4'h0 : pri_cnt + 4'(!primary_osc_ready);
            sec_cnt <= !secondary_osc_enable ? 4'h0 : sec_cnt + 4'(!secondary_osc_running);
        end
    end
endmodule

// ---- bench/tb_sleep_idle_mode_control.sv ----
// self-checking bench for the sleep and idle mode controller
`timescale 1ns/10ps
module tb_sleep_idle_mode_control;
    import pm_mode_pkg::*;
    localparam int SETTLE = 3;
    logic clk_sys = 1'b0, rst_n = 1'b0, sleep_exec = 1'b0, idle_on_sleep_select = 1'b0;
    logic secondary_osc_enable = 1'b0, low_freq_source_select = 1'b0, watchdog_enable = 1'b1;
    logic fail_safe_enable = 1'b0, two_speed_enable = 1'b0, wake_interrupt = 1'b0, seen;
    logic watchdog_timeout = 1'b0, primary_osc_ready, secondary_osc_running, watchdog_reset_req;
    logic [1:0]     clock_source_select = 2'h0;
    logic [2:0]     internal_freq_select = 3'h0;
    status_type     status;
    clock_ctrl_type clock_ctrl;
    pm_state_type   mode;
    int             n_errors = 0, total_checks = 0, cycles = 0;
    sleep_idle_mode_control #(.CPU_START_LEN(3), .SETTLE_LEN(SETTLE)) dut_u (.*);
    osc_cpu_model model_u (.*);
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic do_sleep(input logic idle, input logic [1:0] sel);
        idle_on_sleep_select = idle;
        clock_source_select = sel;
        sleep_exec = 1'b1;
        step(1);
        sleep_exec = 1'b0;
    endtask
    // wake source is held until the wake is seen, then released before run
    task automatic wake(input logic by_wdt);
        wake_interrupt = !by_wdt;
        watchdog_timeout = by_wdt;
        for (int i = 0; i < 20 && (mode === SLEEP_MODE || mode === IDLE_MODE); i++) step(1);
        wake_interrupt = 1'b0;
        watchdog_timeout = 1'b0;
        for (int i = 0; i < 60 && mode !== RUN_MODE; i++) step(1);
        check(8'(mode), 8'(RUN_MODE));
        step(3);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        step(2);
        rst_n = 1'b1;
        secondary_osc_enable = 1'b1;
        step(12);
        check(8'(clock_ctrl[5:3]), 8'h07);
        do_sleep(1'b0, SEL_PRIMARY);
        check(8'(status), 8'h00);
        check(8'({clock_ctrl.secondary_osc_run, clock_ctrl.low_power_rc_en}), 8'h03);
        wake(1'b0);
        check(8'(status), 8'h04);
        do_sleep(1'b1, SEL_PRIMARY);
        step(10);
        check(8'(mode), 8'(IDLE_MODE));
        check(8'(clock_ctrl[5:3]), 8'h03);
        wake(1'b1);
        check(8'(status), 8'h04);
        secondary_osc_enable = 1'b0;
        do_sleep(1'b1, SEL_SECONDARY);
        check(8'(mode), 8'(RUN_MODE));
        step(4);
        secondary_osc_enable = 1'b1;
        do_sleep(1'b1, SEL_SECONDARY);
        check(8'(clock_ctrl.periph_clock_en), 8'h00);
        step(12);
        check(8'(clock_ctrl[5:3]), 8'h02);
        check(8'(status), 8'h01);
        wake(1'b0);
        check(8'({status, clock_ctrl.secondary_osc_run}), 8'h03);
        do_sleep(1'b1, 2'h3);
        step(5);
        check(8'(clock_ctrl[5:1]), 8'h0A);
        check(8'(status), 8'h00);
        wake(1'b0);
        internal_freq_select = 3'h7;
        do_sleep(1'b1, 2'h2);
        check(8'({status.internal_osc_stable_flag, clock_ctrl.fast_internal_osc_en}), 8'h01);
        step(SETTLE + 4);
        check(8'(status), 8'h02);
        wake(1'b0);
        check(8'(status), 8'h02);
        do_sleep(1'b1, 2'h2);
        check(8'(status), 8'h02);
        wake(1'b0);
        internal_freq_select = 3'h0;
        two_speed_enable = 1'b1;
        do_sleep(1'b0, SEL_PRIMARY);
        wake(1'b0);
        seen = 1'b0;
        watchdog_timeout = 1'b1;
        step(2);
        watchdog_timeout = 1'b0;
        for (int i = 0; i < 5; i++) begin
            step(1);
            seen = seen | watchdog_reset_req;
        end
        check(8'(seen), 8'h01);
        end_sim();
    end
endmodule
